/* design/cmr_controller.sv */
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module cmr_controller (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_b,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Mode word link.
  cmr_if.controller        link
);
  typedef struct packed {
    logic [31:0] word;
    logic [2:0]  req;
    logic [2:0]  gnt;
    logic        desc;
    logic        opLoad;
    logic        opPk;
    logic        keyClr;
    logic        trust;
    logic        rd;
    logic        wr;
    logic [1:0]  inst;
    logic [31:0] out;
    logic [31:0] readBack;
    logic        gotRead;
    logic        gotErr;
    logic [31:0] prdata;
    logic        pslverr;
    logic        ready;
  } cmr_ctl_t;

  cmr_ctl_t st_r;
  cmr_ctl_t st_nxt;
  logic     acc;
  logic     setup;
  logic     badCmd;
  cmr_pkg::cmr_cmd_t cmd;

  // Read data and error are registered at the setup edge, so they stand while pready is high.
  assign acc    = psel && penable && st_r.ready;
  assign setup  = psel && !penable;
  assign cmd    = cmr_pkg::cmr_cmd_t'(pwdata[2:0]);
  assign badCmd = (cmd == cmr_pkg::CMR_CMD_NONE) || (pwdata[2:0] == 3'h7);

  always_comb begin
    st_nxt         = st_r;
    st_nxt.opLoad  = 1'b0;
    st_nxt.opPk    = 1'b0;
    st_nxt.keyClr  = 1'b0;
    st_nxt.trust   = 1'b0;
    st_nxt.rd      = 1'b0;
    st_nxt.wr      = 1'b0;
    st_nxt.pslverr = 1'b0;
    st_nxt.ready   = setup;
    // Device answers set the sticky flags; set beats a software clear.
    if (link.rdValid) begin
      st_nxt.readBack = link.rdata;
    end
    if (acc && pwrite) begin
      case (paddr)
        cmr_pkg::OFS_WORD: st_nxt.word = pwdata;
        cmr_pkg::OFS_REQ: begin
          st_nxt.req  = pwdata[2:0];
          st_nxt.gnt  = pwdata[cmr_pkg::REQ_GNT_LO +: 3];
          st_nxt.desc = pwdata[cmr_pkg::REQ_DESC];
        end
        cmr_pkg::OFS_STATUS: begin
          st_nxt.gotRead = st_r.gotRead && !pwdata[0];
          st_nxt.gotErr  = st_r.gotErr && !pwdata[1];
        end
        cmr_pkg::OFS_CMD: begin
          if (!badCmd) begin
            st_nxt.inst = pwdata[cmr_pkg::CMD_INST_LO +: 2];
          end
          case (cmd)
            cmr_pkg::CMR_CMD_OP_GEN: begin
              st_nxt.opLoad = 1'b1;
              st_nxt.out    = st_r.word & ~cmr_pkg::GEN_RSV_MASK;
            end
            cmr_pkg::CMR_CMD_OP_PK: begin
              st_nxt.opLoad = 1'b1;
              st_nxt.opPk   = 1'b1;
              st_nxt.out    = st_r.word & ~cmr_pkg::PK_RSV_MASK;
            end
            cmr_pkg::CMR_CMD_KEYCLR: st_nxt.keyClr = 1'b1;
            cmr_pkg::CMR_CMD_TRUST:  st_nxt.trust  = 1'b1;
            cmr_pkg::CMR_CMD_READ:   st_nxt.rd     = 1'b1;
            cmr_pkg::CMR_CMD_WRITE: begin
              st_nxt.wr  = 1'b1;
              st_nxt.out = st_r.word;
            end
            default: st_nxt.out = st_r.out;
          endcase
        end
        default: st_nxt.word = st_r.word;
      endcase
    end
    if (setup && pwrite) begin
      case (paddr)
        cmr_pkg::OFS_WORD,
        cmr_pkg::OFS_REQ,
        cmr_pkg::OFS_STATUS: st_nxt.pslverr = 1'b0;
        cmr_pkg::OFS_CMD:    st_nxt.pslverr = badCmd;
        default:             st_nxt.pslverr = 1'b1;
      endcase
    end
    if (link.rdValid) begin
      st_nxt.gotRead = 1'b1;
    end
    if (link.accessErr) begin
      st_nxt.gotErr = 1'b1;
    end
    if (setup && !pwrite) begin
      case (paddr)
        cmr_pkg::OFS_WORD:   st_nxt.prdata = st_r.word;
        cmr_pkg::OFS_REQ:    st_nxt.prdata = {15'h0000, st_r.desc, 5'h00, st_r.gnt,
                                              5'h00, st_r.req};
        cmr_pkg::OFS_RDATA:  st_nxt.prdata = st_r.readBack;
        cmr_pkg::OFS_STATUS: st_nxt.prdata = {30'h0000_0000, st_r.gotErr, st_r.gotRead};
        cmr_pkg::OFS_CMD:    st_nxt.prdata = 32'h0000_0000;
        default: begin
          st_nxt.prdata  = 32'h0000_0000;
          st_nxt.pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata          = st_r.prdata;
  assign pready          = st_r.ready;
  assign pslverr         = st_r.pslverr;
  assign link.opLoad     = st_r.opLoad;
  assign link.opPk       = st_r.opPk;
  assign link.keyClear   = st_r.keyClr;
  assign link.trustClear = st_r.trust;
  assign link.regRead    = st_r.rd;
  assign link.regWrite   = st_r.wr;
  assign link.inst       = st_r.inst;
  assign link.wdata      = st_r.out;
  assign link.instReq    = st_r.req;
  assign link.instGrant  = st_r.gnt;
  assign link.descActive = st_r.desc;
endmodule : cmr_controller
`default_nettype wire

/* design/cmr_pkg.sv */
package cmr_pkg;
  // Instances and word layout.
  localparam int          NUM_INST     = 3;
  localparam logic [31:0] MODE_RESET   = 32'h0000_0000;
  localparam logic [31:0] GEN_RSV_MASK = 32'hff00_c000;
  localparam logic [31:0] PK_RSV_MASK  = 32'hfff0_f000;
  localparam int          PK_UP_HI     = 19;
  localparam int          PK_UP_LO     = 16;
  localparam int          PK_LO_HI     = 11;
  localparam int          ALG_HI       = 23;
  localparam int          ALG_LO       = 16;
  localparam int          C2K_BIT      = 13;
  localparam int          INFO_HI      = 12;
  localparam int          INFO_LO      = 4;
  localparam int          STATE_HI     = 3;
  localparam int          STATE_LO     = 2;
  localparam int          ICV_BIT      = 1;
  localparam int          ENC_BIT      = 0;
  localparam int          DK_BIT       = 8;
  localparam int          PARITY_BIT   = 7;

  // Algorithm codes.
  localparam logic [7:0] ALG_AES    = 8'h10;
  localparam logic [7:0] ALG_DES    = 8'h20;
  localparam logic [7:0] ALG_TDES   = 8'h21;
  localparam logic [7:0] ALG_RNG    = 8'h50;
  localparam logic [7:0] ALG_SNOW   = 8'h60;
  localparam logic [7:0] ALG_KASUMI = 8'h70;
  localparam logic [7:0] ALG_ZUC    = 8'hb0;

  // Information codes (low eight bits of the info field).
  localparam logic [7:0] AES_CTR   = 8'h00;
  localparam logic [7:0] AES_ECB   = 8'h20;
  localparam logic [7:0] AES_CCM   = 8'h80;
  localparam logic [7:0] AES_GCM   = 8'h90;
  localparam logic [7:0] AES_LAST  = 8'he0;
  localparam logic [6:0] DES_FIRST = 7'h10;
  localparam logic [6:0] DES_LAST  = 7'h40;
  localparam logic [7:0] KAS_GSM   = 8'h10;
  localparam logic [7:0] KAS_EDGE  = 8'h20;
  localparam logic [7:0] KAS_F8    = 8'hc0;
  localparam logic [7:0] KAS_F9    = 8'hc8;
  localparam logic [7:0] STREAM_C0 = 8'hc0;
  localparam logic [7:0] RNG_PLAIN = 8'h00;
  localparam logic [7:0] RNG_NOZ   = 8'h10;
  localparam logic [7:0] RNG_ODD   = 8'h20;

  // Public key function types, as given by the accelerator.
  typedef enum logic [1:0] {
    CMR_PK_CLEAR = 2'h0,
    CMR_PK_ARITH = 2'h1,
    CMR_PK_COPY  = 2'h3
  } cmr_pk_type_t;

  // Commands from controller software.
  typedef enum logic [2:0] {
    CMR_CMD_NONE   = 3'h0,
    CMR_CMD_OP_GEN = 3'h1,
    CMR_CMD_OP_PK  = 3'h2,
    CMR_CMD_KEYCLR = 3'h3,
    CMR_CMD_TRUST  = 3'h4,
    CMR_CMD_READ   = 3'h5,
    CMR_CMD_WRITE  = 3'h6
  } cmr_cmd_t;

  // Controller APB register map.
  localparam logic [7:0] OFS_WORD   = 8'h00;
  localparam logic [7:0] OFS_CMD    = 8'h04;
  localparam logic [7:0] OFS_REQ    = 8'h08;
  localparam logic [7:0] OFS_RDATA  = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam int         CMD_INST_LO = 4;
  localparam int         REQ_GNT_LO  = 8;
  localparam int         REQ_DESC    = 16;

  // Mode error for an information code the algorithm does not define.
  function automatic logic info_bad(input logic [7:0] algorithm_select, input logic [8:0] info,
                                    input logic c2k);
    logic [7:0] c;
    c = info[7:0];
    case (algorithm_select)
      ALG_AES:    info_bad = (c[3:0] != 4'h0) || (c > AES_LAST)
                             || (c2k && c != AES_CCM && c != AES_GCM);
      ALG_DES,
      ALG_TDES:   info_bad = info[DK_BIT] || c[6:0] < DES_FIRST || c[6:0] > DES_LAST
                             || c[3:0] != 4'h0;
      ALG_KASUMI: info_bad = info[DK_BIT] || !(c == KAS_GSM || c == KAS_EDGE
                             || c == KAS_F8 || c == KAS_F9);
      ALG_ZUC,
      ALG_SNOW:   info_bad = info != {1'b0, STREAM_C0};
      ALG_RNG:    info_bad = info[DK_BIT] || !(c == RNG_PLAIN || c == RNG_NOZ
                             || c == RNG_ODD);
      default:    info_bad = 1'b1;
    endcase
  endfunction : info_bad
endpackage : cmr_pkg

/* design/cmr_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface cmr_if;
  logic        opLoad;
  logic        opPk;
  logic        keyClear;
  logic        trustClear;
  logic        regRead;
  logic        regWrite;
  logic [1:0]  inst;
  logic [31:0] wdata;
  logic [2:0]  instReq;
  logic [2:0]  instGrant;
  logic        descActive;
  logic [31:0] rdata;
  logic        rdValid;
  logic        accessErr;

  modport device (
    input  opLoad, opPk, keyClear, trustClear, regRead, regWrite, inst, wdata,
    input  instReq, instGrant, descActive,
    output rdata, rdValid, accessErr
  );
  modport controller (
    output opLoad, opPk, keyClear, trustClear, regRead, regWrite, inst, wdata,
    output instReq, instGrant, descActive,
    input  rdata, rdValid, accessErr
  );
endinterface : cmr_if
`default_nettype wire

/* design/cmr_device.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Public-key word splits function mode 19-16, 11-0
// - Function mode decoded per public-key function type
// - Three words, reachable only with request and grant; operation loads and clears here skip the grant check
// - Operation command loads; descriptor blocks other writes
// - Key encrypt/decrypt clears the word
// - Trusted descriptor check or re-sign clears word
// - Builder zeroes general reserved bits
// - Bits 23-16 select the algorithm
// - Bit 13 picks key for CCM/GCM
// - Bits 12-4 carry info; unused means zero
// - AES info codes select the cipher mode
// - AES info top bit selects decrypt key
// - Info codes never combined by OR
// - Kasumi info selects GSM, EDGE, f8, f9
// - ZUC info C0h selects encryption
// - DES info selects mode; 80h adds parity
// - Random generator info selects output filtering
// - SNOW info C0h selects f8
// - Bits 3-2 give algorithm state
// - Bit 1 requests ICV compare outside ECB
// - Bit 1 injects faults in AES ECB
// - Bit 0 set encrypts, clear decrypts
module cmr_device #(
  parameter int NINST = cmr_pkg::NUM_INST
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Descriptor controller side.
  cmr_if.device            link,
  // Accelerator side.
  input  wire logic [1:0]  accelInst,
  input  wire logic [1:0]  pkFuncType,
  output logic [7:0]       algSelect,
  output logic [7:0]       infoCode,
  output logic             decryptKey,
  output logic             useSecondKey,
  output logic             desParity,
  output logic [1:0]       algState,
  output logic             icvCheck,
  output logic             faultInject,
  output logic             encrypt,
  output logic             modeError,
  output logic             pkActive,
  output logic [15:0]      pkClearMode,
  output logic [15:0]      pkArithMode,
  output logic [15:0]      pkCopyMode
);
  if (NINST != cmr_pkg::NUM_INST) begin : g_bad_ninst
    $error("NINST must equal three");
  end

  typedef struct packed {
    logic [2:0][31:0] mode;
    logic [2:0]       isPk;
    logic [31:0]      rdata;
    logic             rdValid;
    logic             accessErr;
    logic [7:0]       algorithm_select;
    logic [7:0]       info;
    logic             dk;
    logic             c2k;
    logic             parity;
    logic [1:0]       state;
    logic             icv;
    logic             fault;
    logic             encrypt_select;
    logic             err;
    logic             pk;
    logic [15:0]      pkClr;
    logic [15:0]      pkAri;
    logic [15:0]      pkCpy;
  } cmr_dev_t;

  cmr_dev_t st_r;
  cmr_dev_t st_nxt;

  logic        granted;
  logic [31:0] w;
  logic [8:0]  algorithm_info;
  logic [15:0] pkMode;
  logic        ecb;

  assign granted = link.instReq[link.inst] && link.instGrant[link.inst];

  always_comb begin
    st_nxt           = st_r;
    st_nxt.rdValid   = 1'b0;
    st_nxt.accessErr = 1'b0;
    // Clears come first so that an operation load in the same cycle survives.
    if (link.keyClear || link.trustClear) begin
      st_nxt.mode[link.inst] = cmr_pkg::MODE_RESET;
      st_nxt.isPk[link.inst] = 1'b0;
    end
    if (link.opLoad) begin
      st_nxt.mode[link.inst] = link.wdata;
      st_nxt.isPk[link.inst] = link.opPk;
    end else if (link.regWrite) begin
      // A running descriptor may only change the word through operation loads and clears.
      if (granted && !link.descActive) begin
        st_nxt.mode[link.inst] = link.wdata;
      end else begin
        st_nxt.accessErr = 1'b1;
      end
    end
    if (link.regRead) begin
      if (granted) begin
        st_nxt.rdata   = st_r.mode[link.inst];
        st_nxt.rdValid = 1'b1;
      end else begin
        st_nxt.accessErr = 1'b1;
      end
    end

    // Decode of the word selected by the accelerator.
    w      = st_r.mode[accelInst];
    algorithm_info    = w[cmr_pkg::INFO_HI:cmr_pkg::INFO_LO];
    pkMode = {w[cmr_pkg::PK_UP_HI:cmr_pkg::PK_UP_LO], w[cmr_pkg::PK_LO_HI:0]};
    ecb    = (w[cmr_pkg::ALG_HI:cmr_pkg::ALG_LO] == cmr_pkg::ALG_AES)
             && (algorithm_info[7:0] == cmr_pkg::AES_ECB);
    st_nxt.pk    = st_r.isPk[accelInst];
    st_nxt.pkClr = (st_r.isPk[accelInst] && pkFuncType == cmr_pkg::CMR_PK_CLEAR)
                   ? pkMode : 16'h0000;
    st_nxt.pkAri = (st_r.isPk[accelInst] && pkFuncType == cmr_pkg::CMR_PK_ARITH)
                   ? pkMode : 16'h0000;
    st_nxt.pkCpy = (st_r.isPk[accelInst] && pkFuncType == cmr_pkg::CMR_PK_COPY)
                   ? pkMode : 16'h0000;
    if (st_r.isPk[accelInst]) begin
      st_nxt.algorithm_select    = 8'h00;
      st_nxt.info   = 8'h00;
      st_nxt.dk     = 1'b0;
      st_nxt.c2k    = 1'b0;
      st_nxt.parity = 1'b0;
      st_nxt.state  = 2'h0;
      st_nxt.icv    = 1'b0;
      st_nxt.fault  = 1'b0;
      st_nxt.encrypt_select    = 1'b0;
      st_nxt.err    = 1'b0;
    end else begin
      st_nxt.algorithm_select  = w[cmr_pkg::ALG_HI:cmr_pkg::ALG_LO];
      st_nxt.info = algorithm_info[7:0];
      // Only AES reads the decrypt-key and second-key bits.
      st_nxt.dk  = (st_nxt.algorithm_select == cmr_pkg::ALG_AES) && algorithm_info[cmr_pkg::DK_BIT];
      st_nxt.c2k = (st_nxt.algorithm_select == cmr_pkg::ALG_AES) && w[cmr_pkg::C2K_BIT];
      st_nxt.parity = (st_nxt.algorithm_select == cmr_pkg::ALG_DES || st_nxt.algorithm_select == cmr_pkg::ALG_TDES)
                      && algorithm_info[cmr_pkg::PARITY_BIT];
      st_nxt.state = w[cmr_pkg::STATE_HI:cmr_pkg::STATE_LO];
      st_nxt.icv   = w[cmr_pkg::ICV_BIT] && !ecb;
      st_nxt.fault = w[cmr_pkg::ICV_BIT] && ecb;
      st_nxt.encrypt_select   = w[cmr_pkg::ENC_BIT];
      st_nxt.err   = cmr_pkg::info_bad(st_nxt.algorithm_select, algorithm_info, w[cmr_pkg::C2K_BIT]);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign link.rdata     = st_r.rdata;
  assign link.rdValid   = st_r.rdValid;
  assign link.accessErr = st_r.accessErr;
  assign algSelect      = st_r.algorithm_select;
  assign infoCode       = st_r.info;
  assign decryptKey     = st_r.dk;
  assign useSecondKey   = st_r.c2k;
  assign desParity      = st_r.parity;
  assign algState       = st_r.state;
  assign icvCheck       = st_r.icv;
  assign faultInject    = st_r.fault;
  assign encrypt        = st_r.encrypt_select;
  assign modeError      = st_r.err;
  assign pkActive       = st_r.pk;
  assign pkClearMode    = st_r.pkClr;
  assign pkArithMode    = st_r.pkAri;
  assign pkCopyMode     = st_r.pkCpy;
endmodule : cmr_device
`default_nettype wire

/* dv/cmr_props.sv */
`timescale 1ns/1ps
`default_nettype none
module cmr_props (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        rst_b,
  // Link requests.
  input wire logic        opLoad,
  input wire logic        opPk,
  input wire logic        keyClear,
  input wire logic        trustClear,
  input wire logic        regRead,
  input wire logic        regWrite,
  input wire logic [1:0]  inst,
  input wire logic [31:0] wdata,
  input wire logic [2:0]  instReq,
  input wire logic [2:0]  instGrant,
  input wire logic        descActive,
  // Link answers.
  input wire logic [31:0] rdata,
  input wire logic        rdValid,
  input wire logic        accessErr
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  logic [2:0][31:0] word_r;
  logic [31:0]      expRd_r;
  logic             granted;

  assign granted = instReq[inst] & instGrant[inst];

  // A shadow of the words lets read data be judged end to end, masks and clears included.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      word_r  <= '0;
      expRd_r <= '0;
    end else begin
      if (regRead) begin
        expRd_r <= word_r[inst];
      end
      if (opLoad) begin
        word_r[inst] <= wdata & ~(opPk ? cmr_pkg::PK_RSV_MASK : cmr_pkg::GEN_RSV_MASK);
      end else if (keyClear || trustClear) begin
        word_r[inst] <= cmr_pkg::MODE_RESET;
      end else if (regWrite && granted && !descActive) begin
        word_r[inst] <= wdata;
      end
    end
  end

  a_read_granted: assert property (regRead && granted |=> rdValid && !accessErr)
    else $error("granted read not answered");
  a_read_refused: assert property (regRead && !granted |=> accessErr && !rdValid)
    else $error("ungranted read not refused");
  a_write_granted: assert property (regWrite && granted && !descActive |=> !accessErr)
    else $error("granted write refused");
  a_write_locked: assert property (regWrite && descActive |=> accessErr && !rdValid)
    else $error("write inside descriptor not refused");
  a_read_data: assert property (rdValid |-> rdata == expRd_r)
    else $error("read data differs from shadow word");
  a_answer_cause: assert property ((rdValid || accessErr) |-> $past(regRead || regWrite))
    else $error("answer without access");
  a_single_cmd: assert property ($onehot0({opLoad,keyClear,trustClear,regRead,regWrite}))
    else $error("two commands at once");
  a_load_pulse: assert property ($rose(opLoad) |=> !opLoad)
    else $error("load pulse too long");

  c_read: cover property (rdValid);
  c_refused: cover property (accessErr);
  c_clear: cover property (keyClear || trustClear);
  c_pk_load: cover property (opLoad && opPk);
endmodule : cmr_props
`default_nettype wire

/* dv/tb_class1_mode_register_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_class1_mode_register_decode;
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, algSelect, infoCode;
  logic [31:0] pwdata, prdata;
  logic [1:0]  accelInst, pkFuncType, algState;
  logic        decryptKey, useSecondKey, desParity, icvCheck, faultInject, encrypt;
  logic        modeError, pkActive;
  logic [15:0] pkClearMode, pkArithMode, pkCopyMode;
  int          num_errors, n_checks;
  // Hand-picked words: the top bit marks a code that must raise a mode error.
  logic [32:0] corner [8] = '{{1'b0, 32'h0010_0202}, {1'b0, 32'h0010_290e},
    {1'b1, 32'h0010_2200}, {1'b1, 32'h0010_0080}, {1'b1, 32'h0070_0300},
    {1'b1, 32'h0030_0000}, {1'b1, 32'h0020_1100}, {1'b1, 32'h0060_0d00}};

  cmr_if link ();
  cmr_device u_cmr_device (
    .clk(clk), .rst_b(rst_b), .link(link), .accelInst(accelInst), .pkFuncType(pkFuncType),
    .algSelect(algSelect), .infoCode(infoCode), .decryptKey(decryptKey),
    .useSecondKey(useSecondKey), .desParity(desParity), .algState(algState),
    .icvCheck(icvCheck), .faultInject(faultInject), .encrypt(encrypt), .modeError(modeError),
    .pkActive(pkActive), .pkClearMode(pkClearMode), .pkArithMode(pkArithMode),
    .pkCopyMode(pkCopyMode));
  cmr_controller u_cmr_controller (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  cmr_props u_cmr_props (
    .clk(clk), .rst_b(rst_b), .opLoad(link.opLoad), .opPk(link.opPk),
    .keyClear(link.keyClear), .trustClear(link.trustClear), .regRead(link.regRead),
    .regWrite(link.regWrite), .inst(link.inst), .wdata(link.wdata), .instReq(link.instReq),
    .instGrant(link.instGrant), .descActive(link.descActive), .rdata(link.rdata),
    .rdValid(link.rdValid), .accessErr(link.accessErr));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic chk_bit(input string n, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask : chk_bit

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      give_verdict();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
    chk_bit("pslverr", ee, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask : rd

  // The wait covers the pulse, the word update and the registered decode.
  task automatic cmd(input logic [1:0] i, input logic [2:0] c);
    wr(cmr_pkg::OFS_CMD, {26'h0, i, 1'b0, c}, 1'b0);
    repeat (3) @(posedge clk);
  endtask : cmd

  task automatic load(input logic [1:0] i, input logic [2:0] c, input logic [31:0] w);
    wr(cmr_pkg::OFS_WORD, w, 1'b0);
    cmd(i, c);
  endtask : load

  task automatic chk_word(input logic [1:0] i, input logic [31:0] e);
    logic [31:0] q;
    cmd(i, 3'h5);
    rd(cmr_pkg::OFS_RDATA, q);
    chk("word", e, q);
  endtask : chk_word

  task automatic chk_gen(input logic [31:0] w, input logic bad);
    logic [7:0] a;
    logic [8:0] f;
    logic       aes;
    logic       ecb;
    a = w[23:16];
    f = w[12:4];
    aes = a == cmr_pkg::ALG_AES;
    ecb = aes && f[7:0] == cmr_pkg::AES_ECB;
    chk_bit("modeError", bad, modeError);
    chk("algSelect", 32'(a), 32'(algSelect));
    chk("infoCode", 32'(f[7:0]), 32'(infoCode));
    chk_bit("decryptKey", aes && f[8], decryptKey);
    if (!bad) chk_bit("useSecondKey", aes && w[13], useSecondKey);
    chk_bit("desParity", (a == cmr_pkg::ALG_DES || a == cmr_pkg::ALG_TDES) && f[7], desParity);
    chk("algState", 32'(w[3:2]), 32'(algState));
    chk_bit("icvCheck", w[1] && !ecb, icvCheck);
    chk_bit("faultInject", w[1] && ecb, faultInject);
    chk_bit("encrypt", w[0], encrypt);
    chk_bit("pkActive", 1'b0, pkActive);
  endtask : chk_gen

  function automatic logic [31:0] rand_gen(input int k);
    logic [31:0] r;
    logic [7:0]  a;
    logic [8:0]  f;
    logic [7:0]  kc [4];
    logic        c2k;
    r = $urandom;
    kc = '{8'h10, 8'h20, 8'hc0, 8'hc8};
    case (k % 7)
      0: a = cmr_pkg::ALG_AES;
      1: a = cmr_pkg::ALG_DES;
      2: a = cmr_pkg::ALG_TDES;
      3: a = cmr_pkg::ALG_KASUMI;
      4: a = cmr_pkg::ALG_SNOW;
      5: a = cmr_pkg::ALG_ZUC;
      default: a = cmr_pkg::ALG_RNG;
    endcase
    case (k % 7)
      0: f = {r[8], 4'(r[7:4] % 4'hf), 4'h0};
      1, 2: f = {1'b0, r[8], 3'(r[5:4]) + 3'h1, 4'h0};
      3: f = {1'b0, kc[r[1:0]]};
      6: f = {3'h0, 2'(r[5:4] % 2'h3), 4'h0};
      default: f = 9'h0c0;
    endcase
    c2k = k % 7 == 0 && (f[7:0] == cmr_pkg::AES_CCM || f[7:0] == cmr_pkg::AES_GCM) && r[9];
    return {8'h0, a, 2'h0, c2k, f, r[13:10]};
  endfunction : rand_gen

  initial begin
    logic [31:0] w;
    logic [15:0] pe;
    logic [1:0]  i;
    {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    accelInst = 2'h0;
    pkFuncType = 2'h0;
    num_errors = 0;
    n_checks = 0;
    void'($urandom(32'he0cf2b48));
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    wr(cmr_pkg::OFS_REQ, 32'h0000_0707, 1'b0);
    for (int k = 0; k < 50; k++) begin
      w = k < 8 ? corner[k][31:0] : rand_gen(k);
      i = 2'(k % 3);
      accelInst <= i;
      load(i, 3'h1, w);
      chk_gen(w, k < 8 && corner[k][32]);
      if (k % 5 == 0) chk_word(i, w);
    end
    for (int t = 0; t < 3; t++) begin
      w = $urandom;
      i = 2'(t);
      accelInst <= i;
      pkFuncType <= t == 2 ? 2'h3 : 2'(t);
      load(i, 3'h2, w);
      pe = {w[19:16], w[11:0]};
      chk("pkClearMode", 32'(t == 0 ? pe : 16'h0), 32'(pkClearMode));
      chk("pkArithMode", 32'(t == 1 ? pe : 16'h0), 32'(pkArithMode));
      chk("pkCopyMode", 32'(t == 2 ? pe : 16'h0), 32'(pkCopyMode));
      chk_bit("pkActive", 1'b1, pkActive);
      chk("algSelect", 32'h0, 32'(algSelect));
      chk_word(i, w & ~cmr_pkg::PK_RSV_MASK);
    end
    load(2'h2, 3'h1, 32'h0010_090f);
    cmd(2'h2, 3'h3);
    chk_word(2'h2, 32'h0);
    chk("algSelect", 32'h0, 32'(algSelect));
    load(2'h2, 3'h1, 32'h0070_0c8e);
    cmd(2'h2, 3'h4);
    chk_word(2'h2, 32'h0);
    wr(cmr_pkg::OFS_STATUS, 32'h3, 1'b0);
    wr(cmr_pkg::OFS_REQ, 32'h0000_0507, 1'b0);
    cmd(2'h1, 3'h5);
    rd(cmr_pkg::OFS_STATUS, w);
    chk("status", 32'h2, w & 32'h3);
    cmd(2'h0, 3'h3);
    wr(cmr_pkg::OFS_REQ, 32'h0001_0707, 1'b0);
    wr(cmr_pkg::OFS_WORD, 32'hffff_ffff, 1'b0);
    cmd(2'h0, 3'h6);
    chk_word(2'h0, 32'h0);
    load(2'h0, 3'h1, 32'h0021_0401);
    chk_word(2'h0, 32'h0021_0401);
    wr(cmr_pkg::OFS_REQ, 32'h0000_0707, 1'b0);
    wr(cmr_pkg::OFS_WORD, 32'hffff_ffff, 1'b0);
    cmd(2'h0, 3'h6);
    chk_word(2'h0, 32'hffff_ffff);
    wr(8'h20, 32'h0, 1'b1);
    wr(cmr_pkg::OFS_CMD, 32'h7, 1'b1);
    give_verdict();
  end
endmodule : tb_class1_mode_register_decode
`default_nettype wire
